// ---- inc/res_pkg.sv ----
// Shared constants and types of the regulator enable sequencer
package res_pkg;
  localparam int RES_CLK_PERIOD_NS = 50;
  localparam int RES_MS_CYC = 1000000 / RES_CLK_PERIOD_NS;
  // Short-circuit window, longest time rounds down
  localparam int RES_SC_TIMEOUT_US = 1000;
  localparam int RES_SC_TIMEOUT_CYC = (RES_SC_TIMEOUT_US * 1000) / RES_CLK_PERIOD_NS;
  // Power-on reset and default load settle time
  localparam int RES_POR_CYC = 16;
  localparam logic [3:0] RES_POR_LAST = 4'hF;

  // Register byte offsets
  localparam logic [7:0] RES_OFF_CTRL = 8'h00;
  localparam logic [7:0] RES_OFF_VHIGH = 8'h04;
  localparam logic [7:0] RES_OFF_VLOW = 8'h08;
  localparam logic [7:0] RES_OFF_DELAY = 8'h0C;
  localparam logic [7:0] RES_OFF_SLEW = 8'h10;
  localparam logic [7:0] RES_OFF_CONFIG = 8'h14;
  localparam logic [7:0] RES_OFF_RESET = 8'h18;
  localparam logic [7:0] RES_OFF_FLAGS = 8'h1C;
  localparam logic [7:0] RES_OFF_MASK = 8'h20;
  localparam logic [7:0] RES_OFF_STATUS = 8'h24;

  // Control, delay and reset register fields
  localparam int RES_CTRL_EN = 0;
  localparam int RES_CTRL_PINCTL = 1;
  localparam int RES_CTRL_PINSEL = 2;
  localparam int RES_CTRL_DUAL = 3;
  localparam int RES_CTRL_FFQ = 4;
  localparam int RES_CTRL_FAP = 5;
  localparam int RES_DELAY_FALL_LSB = 4;
  localparam int RES_SWRST_BIT = 0;
  // Flag and mask fields
  localparam int RES_FLAG_PG = 0;
  localparam int RES_FLAG_SC = 1;
  localparam int RES_FLAG_RST = 2;
  localparam int RES_MASK_PG = 0;
  localparam int RES_MASK_RST = 1;

  // Default values; control, voltage, delay and slew ones are one-time-programmable
  localparam logic [5:0] RES_CTRL_RST = 6'h00;
  localparam logic [7:0] RES_VHIGH_RST = 8'h00;
  localparam logic [7:0] RES_VLOW_RST = 8'h00;
  localparam logic [7:0] RES_DELAY_RST = 8'h00;
  localparam logic [2:0] RES_SLEW_RST = 3'h0;
  localparam logic [1:0] RES_PD_RST = 2'h3;
  localparam logic [1:0] RES_MASK_RST_VAL = 2'h0;

  localparam logic [2:0] RES_PHASES_ALL = 3'h4;
  localparam logic [1:0] RES_RESP_OKAY = 2'h0;
  localparam logic [1:0] RES_RESP_SLVERR = 2'h2;

  // Delay code to cycles, half a millisecond per code step by default
  localparam int RES_DLY_TABLE_CYC [16] = '{
    0, RES_MS_CYC / 2, RES_MS_CYC, 3 * RES_MS_CYC / 2, 2 * RES_MS_CYC, 5 * RES_MS_CYC / 2,
    3 * RES_MS_CYC, 7 * RES_MS_CYC / 2, 4 * RES_MS_CYC, 9 * RES_MS_CYC / 2, 5 * RES_MS_CYC,
    11 * RES_MS_CYC / 2, 6 * RES_MS_CYC, 13 * RES_MS_CYC / 2, 7 * RES_MS_CYC, 15 * RES_MS_CYC / 2};
  // Slew code to cycles per voltage-code step, code 0 is fastest
  localparam int RES_SLEW_STEP_CYC [8] = '{1, 2, 4, 8, 16, 32, 64, 128};

  typedef enum logic [1:0] {RES_ST_POR, RES_ST_OFF, RES_ST_SOFT, RES_ST_RUN} res_state_t;
endpackage

// ---- verilog/res_pin_delay.sv ----
// Rise/fall delay filter for the selected enable pin
`timescale 1ns/10ps
module res_pin_delay (
  input wire logic aclk,
  input wire logic clear,
  input wire logic pin_level,
  input wire logic [19:0] rise_cyc,
  input wire logic [19:0] fall_cyc,
  output logic delayed_reg
);
  logic [19:0] cnt_reg;
  logic pin_q_reg;

  // An edge restarts the count, so a pulse shorter than the delay is swallowed
  always_ff @(posedge aclk) begin
    if (clear) begin
      pin_q_reg <= 1'b0;
      cnt_reg <= 20'h00000;
      delayed_reg <= 1'b0;
    end else begin
      pin_q_reg <= pin_level;
      if (pin_level != pin_q_reg) begin
        cnt_reg <= 20'h00000;
      end else if (pin_level != delayed_reg) begin
        if (cnt_reg >= (pin_level ? rise_cyc : fall_cyc)) begin
          delayed_reg <= pin_level;
        end else begin
          cnt_reg <= cnt_reg + 20'h00001;
        end
      end
    end
  end
endmodule

// ---- verilog/res_slew_ramp.sv ----
// Slew-controlled voltage code ramp
`timescale 1ns/10ps
module res_slew_ramp (
  input wire logic aclk,
  input wire logic clear,
  input wire logic run,
  input wire logic [7:0] target,
  input wire logic [7:0] step_cyc,
  output logic [7:0] code_reg,
  output logic busy_reg
);
  logic [7:0] tick_reg;

  always_ff @(posedge aclk) begin
    if (clear || !run) begin
      code_reg <= 8'h00;
      tick_reg <= 8'h00;
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (code_reg != target);
      if (code_reg == target) begin
        tick_reg <= 8'h00;
      end else if (tick_reg + 8'h01 >= step_cyc) begin
        tick_reg <= 8'h00;
        code_reg <= (code_reg < target) ? code_reg + 8'h01 : code_reg - 8'h01;
      end else begin
        tick_reg <= tick_reg + 8'h01;
      end
    end
  end

  step_size_a: assert property (@(posedge aclk) disable iff (clear)
    run && $past(run) |-> (code_reg - $past(code_reg) <= 8'h01) || ($past(code_reg) - code_reg <= 8'h01))
    else $error("ramp moved more than one code step");
endmodule

// ---- verilog/res_regulator_sequencer.sv ----
// Regulator enable sequencer with AXI4-Lite registers
`timescale 1ns/10ps
module res_regulator_sequencer
  import res_pkg::*;
#(
  parameter int SC_TIMEOUT_CYC = RES_SC_TIMEOUT_CYC,
  parameter int DLY_TABLE_CYC [16] = RES_DLY_TABLE_CYC,
  parameter logic [5:0] OTP_CTRL = RES_CTRL_RST,
  parameter logic [7:0] OTP_VHIGH = RES_VHIGH_RST,
  parameter logic [7:0] OTP_VLOW = RES_VLOW_RST,
  parameter logic [7:0] OTP_DELAY = RES_DELAY_RST,
  parameter logic [2:0] OTP_SLEW = RES_SLEW_RST
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hard_reset_pin,
  input wire logic analog_supply_ok,
  input wire logic enable_pin_a,
  input wire logic enable_pin_b,
  input wire logic vout_above_soft,
  input wire logic vout_above_sc,
  input wire logic vout_good,
  input wire logic load_pwm_req,
  input wire logic [2:0] load_phase_req,
  output logic regulator_on,
  output logic soft_start_on,
  output logic [7:0] vout_code,
  output logic forced_pwm,
  output logic [2:0] active_phases,
  output logic pin_pulldown_enable_a,
  output logic pin_pulldown_enable_b,
  output logic irq_pin_n
);
  localparam logic [19:0] SC_LAST = 20'(SC_TIMEOUT_CYC - 1);

  // Register file: only one set of control registers exists, the master's
  logic [5:0] ctrl_reg;
  logic [7:0] vhigh_reg;
  logic [7:0] vlow_reg;
  logic [3:0] rise_code_reg;
  logic [3:0] fall_code_reg;
  logic [2:0] slew_reg;
  logic [1:0] pd_reg;
  logic [2:0] flag_reg;
  logic [1:0] mask_reg;
  logic soft_rst_reg;

  // Bus state
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic wr_strb0_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // Sequencer state
  res_state_t state_reg, state_next;
  logic [3:0] por_cnt_reg;
  logic [19:0] sc_cnt_reg;
  logic sc_ok_reg, sc_block_reg, vgood_q_reg;
  logic reg_on_reg, soft_on_reg, pwm_reg, irq_n_reg;
  logic [2:0] phases_reg;

  logic reg_rst, wr_fire, wr_hit, rd_hit;
  logic pin_mode, pin_raw, pin_dly, want_on, sc_trip, por_done, pg_rise, ramp_busy;
  logic [7:0] target_code, ramp_code;
  logic [2:0] flag_set, flag_clr, unmasked;
  logic [31:0] rd_mux;

  // Bus logic is kept out of the soft reset so a running access completes
  assign reg_rst = !aresetn || !hard_reset_pin || !analog_supply_ok || soft_rst_reg;
  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_hit = wr_fire && wr_strb0_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RES_RESP_OKAY;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 32'h00000000;
      wr_strb0_reg <= 1'b0;
    end else begin
      if (awready_reg && s_axi_awvalid) begin
        awready_reg <= 1'b0;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (wready_reg && s_axi_wvalid) begin
        wready_reg <= 1'b0;
        wr_data_reg <= s_axi_wdata;
        wr_strb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_addr_reg[7:2] <= RES_OFF_STATUS[7:2]) ? RES_RESP_OKAY : RES_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      RES_OFF_CTRL: rd_mux[5:0] = ctrl_reg;
      RES_OFF_VHIGH: rd_mux[7:0] = vhigh_reg;
      RES_OFF_VLOW: rd_mux[7:0] = vlow_reg;
      RES_OFF_DELAY: rd_mux[7:0] = {fall_code_reg, rise_code_reg};
      RES_OFF_SLEW: rd_mux[2:0] = slew_reg;
      RES_OFF_CONFIG: rd_mux[1:0] = pd_reg;
      RES_OFF_RESET: rd_mux = 32'h00000000;
      RES_OFF_FLAGS: rd_mux[2:0] = flag_reg;
      RES_OFF_MASK: rd_mux[1:0] = mask_reg;
      RES_OFF_STATUS: rd_mux[17:0] = {ramp_code, phases_reg, pwm_reg, ramp_busy, soft_on_reg, reg_on_reg, pin_dly,
                                      sc_block_reg, state_reg == RES_ST_POR};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RES_RESP_OKAY;
    end else if (arready_reg && s_axi_arvalid) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_hit ? RES_RESP_OKAY : RES_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Configuration registers reload their default values on every reset source
  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      ctrl_reg <= OTP_CTRL;
      vhigh_reg <= OTP_VHIGH;
      vlow_reg <= OTP_VLOW;
      {fall_code_reg, rise_code_reg} <= OTP_DELAY;
      slew_reg <= OTP_SLEW;
      pd_reg <= RES_PD_RST;
      mask_reg <= RES_MASK_RST_VAL;
    end else if (wr_hit) begin
      unique case ({wr_addr_reg[7:2], 2'b00})
        RES_OFF_CTRL: ctrl_reg <= wr_data_reg[5:0];
        RES_OFF_VHIGH: vhigh_reg <= wr_data_reg[7:0];
        RES_OFF_VLOW: vlow_reg <= wr_data_reg[7:0];
        RES_OFF_DELAY: {fall_code_reg, rise_code_reg} <= wr_data_reg[7:0];
        RES_OFF_SLEW: slew_reg <= wr_data_reg[2:0];
        RES_OFF_CONFIG: pd_reg <= wr_data_reg[1:0];
        RES_OFF_MASK: mask_reg <= wr_data_reg[1:0];
        default: ;
      endcase
    end
  end

  // Self-clearing trigger: a single-cycle pulse, register always reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_hit && ({wr_addr_reg[7:2], 2'b00} == RES_OFF_RESET) && wr_data_reg[RES_SWRST_BIT];
    end
  end

  assign flag_set[RES_FLAG_PG] = pg_rise;
  assign flag_set[RES_FLAG_SC] = sc_trip;
  assign flag_set[RES_FLAG_RST] = por_done;
  assign flag_clr = (wr_hit && ({wr_addr_reg[7:2], 2'b00} == RES_OFF_FLAGS)) ? wr_data_reg[2:0] : 3'h0;
  assign unmasked = flag_reg & ~{mask_reg[RES_MASK_RST], 1'b0, mask_reg[RES_MASK_PG]};

  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      flag_reg <= 3'h0;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= !(|unmasked);
    end
  end

  // Enable source selection
  assign pin_mode = ctrl_reg[RES_CTRL_EN] && ctrl_reg[RES_CTRL_PINCTL];
  assign pin_raw = ctrl_reg[RES_CTRL_PINSEL] ? enable_pin_b : enable_pin_a;
  assign want_on = ctrl_reg[RES_CTRL_EN] && (!ctrl_reg[RES_CTRL_PINCTL] || ctrl_reg[RES_CTRL_DUAL] || pin_dly);
  assign target_code = (pin_mode && ctrl_reg[RES_CTRL_DUAL] && !pin_raw) ? vlow_reg : vhigh_reg;

  // Exact cycle counts from the table give far better than ten percent accuracy
  res_pin_delay u_pin_delay (
    .aclk(aclk),
    .clear(reg_rst || !pin_mode || ctrl_reg[RES_CTRL_DUAL]),
    .pin_level(pin_raw),
    .rise_cyc(20'(DLY_TABLE_CYC[rise_code_reg])),
    .fall_cyc(20'(DLY_TABLE_CYC[fall_code_reg])),
    .delayed_reg(pin_dly)
  );

  res_slew_ramp u_ramp (
    .aclk(aclk),
    .clear(reg_rst),
    .run(state_reg == RES_ST_RUN),
    .target(target_code),
    .step_cyc(8'(RES_SLEW_STEP_CYC[slew_reg])),
    .code_reg(ramp_code),
    .busy_reg(ramp_busy)
  );

  assign por_done = (state_reg == RES_ST_POR) && (por_cnt_reg == RES_POR_LAST);
  assign sc_trip = (state_reg == RES_ST_SOFT || state_reg == RES_ST_RUN) && !sc_ok_reg && !vout_above_sc
                   && (sc_cnt_reg == SC_LAST);
  assign pg_rise = (state_reg == RES_ST_RUN) && vout_good && !vgood_q_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RES_ST_POR: if (por_done) state_next = RES_ST_OFF;
      RES_ST_OFF: if (want_on && !sc_block_reg) state_next = RES_ST_SOFT;
      RES_ST_SOFT: begin
        if (!want_on || sc_trip) state_next = RES_ST_OFF;
        else if (vout_above_soft) state_next = RES_ST_RUN;
      end
      RES_ST_RUN: if (!want_on || sc_trip) state_next = RES_ST_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      state_reg <= RES_ST_POR;
      por_cnt_reg <= 4'h0;
      reg_on_reg <= 1'b0;
      soft_on_reg <= 1'b0;
      vgood_q_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == RES_ST_POR) por_cnt_reg <= por_cnt_reg + 4'h1;
      reg_on_reg <= (state_next == RES_ST_SOFT) || (state_next == RES_ST_RUN);
      soft_on_reg <= (state_next == RES_ST_SOFT);
      vgood_q_reg <= vout_good;
    end
  end

  // Short-circuit window is measured from enable; a trip holds off until enable drops
  always_ff @(posedge aclk) begin
    if (reg_rst || state_reg == RES_ST_OFF || state_reg == RES_ST_POR) begin
      sc_cnt_reg <= 20'h00000;
      sc_ok_reg <= 1'b0;
    end else begin
      if (vout_above_sc) sc_ok_reg <= 1'b1;
      if (sc_cnt_reg != SC_LAST) sc_cnt_reg <= sc_cnt_reg + 20'h00001;
    end
  end

  always_ff @(posedge aclk) begin
    if (reg_rst || !want_on) begin
      sc_block_reg <= 1'b0;
    end else if (sc_trip) begin
      sc_block_reg <= 1'b1;
    end
  end

  // Phase count while ramping follows slew code unless FAP is set: faster slews need more phases
  always_ff @(posedge aclk) begin
    if (reg_rst || state_reg != RES_ST_RUN) begin
      pwm_reg <= 1'b0;
      phases_reg <= 3'h0;
    end else if (ramp_busy) begin
      pwm_reg <= 1'b1;
      phases_reg <= ctrl_reg[RES_CTRL_FAP] ? RES_PHASES_ALL : RES_PHASES_ALL - {1'b0, slew_reg[2:1]};
    end else begin
      pwm_reg <= ctrl_reg[RES_CTRL_FFQ] || ctrl_reg[RES_CTRL_FAP] || load_pwm_req;
      phases_reg <= ctrl_reg[RES_CTRL_FAP] ? RES_PHASES_ALL : load_phase_req;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign regulator_on = reg_on_reg;
  assign soft_start_on = soft_on_reg;
  assign vout_code = ramp_code;
  assign forced_pwm = pwm_reg;
  assign active_phases = phases_reg;
  assign pin_pulldown_enable_a = pd_reg[0];
  assign pin_pulldown_enable_b = pd_reg[1];
  assign irq_pin_n = irq_n_reg;

  por_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == RES_ST_POR |=> state_reg == RES_ST_POR || state_reg == RES_ST_OFF)
    else $error("left power-on reset other than to standby");
  bit_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == RES_ST_OFF && ctrl_reg[RES_CTRL_EN] && !ctrl_reg[RES_CTRL_PINCTL] && !sc_block_reg && !reg_rst
    |=> regulator_on && soft_start_on)
    else $error("enable bit did not start regulator next cycle");
  pin_low_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_mode && !ctrl_reg[RES_CTRL_DUAL] && !pin_dly && !reg_rst |=> !regulator_on)
    else $error("regulator on while delayed pin low");
  dual_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == RES_ST_RUN && pin_mode && ctrl_reg[RES_CTRL_DUAL] && !sc_trip && !reg_rst |=> regulator_on)
    else $error("dual level mode turned regulator off");
  sc_trip_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sc_trip && !reg_rst |=> (!regulator_on && flag_reg[RES_FLAG_SC]) ##1 !irq_pin_n)
    else $error("short trip did not disable and flag");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    |unmasked |=> !irq_pin_n)
    else $error("interrupt pin high with pending flag");
  w1c_a: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_clr[RES_FLAG_PG] && !pg_rise && !reg_rst |=> !flag_reg[RES_FLAG_PG])
    else $error("write one did not clear output good flag");
  soft_rst_a: assert property (@(posedge aclk) disable iff (!aresetn)
    soft_rst_reg |=> state_reg == RES_ST_POR && !regulator_on && !soft_rst_reg && ctrl_reg == OTP_CTRL)
    else $error("soft reset did not restore defaults");
  ramp_pwm_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == RES_ST_RUN && ramp_busy && ctrl_reg[RES_CTRL_FAP] && !reg_rst && !sc_trip && want_on
    |=> forced_pwm && active_phases == RES_PHASES_ALL)
    else $error("ramp without forced all phases");
  rst_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    por_done && !reg_rst |=> flag_reg[RES_FLAG_RST])
    else $error("registers reset flag not set at start-up");
endmodule

// ---- tb/res_far_model.sv ----
// Far-side model: output voltage sense lines seen by the sequencer
`timescale 1ns/10ps
module res_far_model (
  input wire logic aclk,
  input wire logic regulator_on,
  input wire logic soft_start_on,
  input wire logic short_out,
  output logic vout_above_soft,
  output logic vout_above_sc,
  output logic vout_good
);
  logic [1:0] rise_reg = 2'h0;
  // Output needs a few cycles to climb; a shorted output never climbs
  always_ff @(posedge aclk) begin
    if (!regulator_on || short_out) rise_reg <= 2'h0;
    else if (rise_reg != 2'h3) rise_reg <= rise_reg + 2'h1;
  end
  assign vout_above_soft = rise_reg == 2'h3;
  assign vout_above_sc = rise_reg == 2'h3;
  assign vout_good = regulator_on && !soft_start_on && !short_out;
endmodule

// ---- tb/res_regulator_sequencer_bench.sv ----
// Bench of the regulator enable sequencer
`timescale 1ns/10ps
module res_regulator_sequencer_bench;
  import res_pkg::*;
  localparam int DT [16] = '{0, 4, 8, 12, 16, 20, 24, 28, 32, 36, 40, 44, 48, 52, 56, 60};
  // Host hold-off after the reset pin rises
  localparam int HOST_WAIT = 6 * RES_MS_CYC / 5;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic hrst = 1, supply = 1, short_out = 0, awready, wready, bvalid, arready, rvalid;
  logic reg_on, soft_on, fpwm, pd_a, pd_b, irq_n, a_soft, a_sc, good;
  logic lpwm = 1'h0;
  logic [2:0] lph = 3'h1;
  logic [1:0] pins = 0, bresp, rresp;
  logic [7:0] awaddr = 0, araddr = 0, vcode;
  logic [31:0] wdata = 0, rdata;
  logic [2:0] phases;
  logic [34:0] exp_q [$];
  int bad_count = 0, comparisons = 0;

  res_regulator_sequencer #(.SC_TIMEOUT_CYC(50), .DLY_TABLE_CYC(DT)) res_regulator_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hard_reset_pin(hrst), .analog_supply_ok(supply), .enable_pin_a(pins[0]),
    .enable_pin_b(pins[1]), .vout_above_soft(a_soft), .vout_above_sc(a_sc), .vout_good(good),
    .load_pwm_req(lpwm), .load_phase_req(lph), .regulator_on(reg_on), .soft_start_on(soft_on),
    .vout_code(vcode), .forced_pwm(fpwm), .active_phases(phases), .pin_pulldown_enable_a(pd_a),
    .pin_pulldown_enable_b(pd_b), .irq_pin_n(irq_n));
  res_far_model res_far_model_i (.aclk(aclk), .regulator_on(reg_on), .soft_start_on(soft_on),
    .short_out(short_out), .vout_above_soft(a_soft), .vout_above_sc(a_sc), .vout_good(good));

  initial begin
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RES_RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'h0;
      if (wready && wvalid) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  // Expected read result is queued; the monitor below judges it
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RES_RESP_OKAY);
    exp_q.push_back({er != RES_RESP_SLVERR, er, e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    rready <= 1'h0;
  endtask

  always @(posedge aclk) begin
    if (rvalid && rready) begin
      chk("rresp", {30'h0, exp_q[0][33:32]}, {30'h0, rresp});
      if (exp_q[0][34]) chk("rdata", exp_q[0][31:0], rdata);
      void'(exp_q.pop_front());
    end
  end

  // Counts edges until the regulator reaches the given state
  task automatic cnt(input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (reg_on !== lvl && n < 200);
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    int r, f, n;
    void'($urandom(32'h2CEFDC4F));
    cyc(5);
    aresetn <= 1'h1;
    cyc(20); // Power-on settle stands in for the host hold-off
    chk("irq start", 32'h0, {31'h0, irq_n});
    rd(RES_OFF_FLAGS, 32'h4);
    rd(RES_OFF_CONFIG, 32'h3);
    wr(RES_OFF_FLAGS, 32'h4);
    cyc(2);
    chk("irq clear", 32'h1, {31'h0, irq_n});
    wr(8'h28, 32'h1, RES_RESP_SLVERR);
    rd(8'h28, 32'h0, RES_RESP_SLVERR);
    pins <= 2'($urandom);
    wr(RES_OFF_MASK, 32'h1);
    wr(RES_OFF_DELAY, 32'hFF);
    wr(RES_OFF_CTRL, 32'h1);
    cyc(2);
    chk("bit enable", 32'h1, {31'h0, reg_on});
    chk("soft start", 32'h1, {31'h0, soft_on});
    cyc(40);
    chk("soft done", 32'h0, {31'h0, soft_on});
    rd(RES_OFF_FLAGS, 32'h1);
    chk("irq masked", 32'h1, {31'h0, irq_n});
    pins <= 2'h0;
    wr(RES_OFF_CTRL, 32'h0);
    wr(RES_OFF_FLAGS, 32'h1);
    wr(RES_OFF_MASK, 32'h0);
    wr(RES_OFF_DELAY, 32'h0);
    wr(RES_OFF_VLOW, 32'h20);
    wr(RES_OFF_VHIGH, 32'h40);
    lpwm <= 1'($urandom);
    lph <= 3'($urandom);
    wr(RES_OFF_CTRL, 32'hB);
    cyc(80);
    chk("floor code", 32'h20, {24'h0, vcode});
    chk("load pwm", {31'h0, lpwm}, {31'h0, fpwm});
    chk("load phases", {29'h0, lph}, {29'h0, phases});
    wr(RES_OFF_CTRL, 32'h2B);
    pins <= 2'h1;
    cyc(80);
    chk("roof code", 32'h40, {24'h0, vcode});
    chk("dual on", 32'h1, {31'h0, reg_on});
    chk("forced pwm", 32'h1, {31'h0, fpwm});
    chk("all phases", {29'h0, RES_PHASES_ALL}, {29'h0, phases});
    pins <= 2'h0;
    wr(RES_OFF_CTRL, 32'h0);
    wr(RES_OFF_FLAGS, 32'h7);
    for (int s = 0; s < 2; s++) begin
      r = 1 + $urandom % 15;
      f = 1 + $urandom % 15;
      wr(RES_OFF_DELAY, {24'h0, 4'(f), 4'(r)});
      pins[1 - s] <= 1'h1;
      wr(RES_OFF_CTRL, 32'h3 | (s << 2));
      cyc(4);
      chk("pin low off", 32'h0, {31'h0, reg_on});
      pins[s] <= 1'h1;
      cnt(1'h1, n);
      chk("rise delay", 32'h1, {31'h0, n >= DT[r] && n <= DT[r] + 5});
      pins[s] <= 1'h0;
      cnt(1'h0, n);
      chk("fall delay", 32'h1, {31'h0, n >= DT[f] && n <= DT[f] + 5});
      pins <= 2'h0;
      wr(RES_OFF_CTRL, 32'h0);
      wr(RES_OFF_FLAGS, 32'h7);
    end
    short_out <= 1'h1;
    wr(RES_OFF_CTRL, 32'h1);
    cyc(70);
    chk("short off", 32'h0, {31'h0, reg_on});
    rd(RES_OFF_FLAGS, 32'h2);
    chk("irq short", 32'h0, {31'h0, irq_n});
    wr(RES_OFF_CTRL, 32'h0);
    wr(RES_OFF_FLAGS, 32'h2);
    short_out <= 1'h0;
    cyc(2);
    chk("irq none", 32'h1, {31'h0, irq_n});
    wr(RES_OFF_VHIGH, 32'h5A);
    wr(RES_OFF_CTRL, 32'h1);
    wr(RES_OFF_RESET, 32'h1);
    cyc(2);
    chk("soft reset off", 32'h0, {31'h0, reg_on});
    cyc(20);
    rd(RES_OFF_VHIGH, 32'h0);
    rd(RES_OFF_RESET, 32'h0);
    rd(RES_OFF_FLAGS, 32'h4);
    for (int k = 0; k < 2; k++) begin
      wr(RES_OFF_CONFIG, 32'h0);
      cyc(2);
      chk("pulldown off", 32'h0, {31'h0, pd_a});
      if (k == 0) hrst <= 1'h0;
      else supply <= 1'h0;
      cyc(3);
      hrst <= 1'h1;
      supply <= 1'h1;
      cyc(k == 0 ? HOST_WAIT : 20);
      rd(RES_OFF_CONFIG, 32'h3);
      chk("pulldown b", 32'h1, {31'h0, pd_b});
    end
    complete_run();
  end

  // Whole run needs about 25000 cycles, mostly host hold-off; over twice that means a hang
  initial begin
    cyc(60000);
    bad_count++;
    complete_run();
  end
endmodule
